// file: dsm_consts.vh
// Constants for the sync gating, monitor and detect control block.
// Assumes a single divided sample clock and one serial control port.
`ifndef DSM_CONSTS_VH
`define DSM_CONSTS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DSM_A_SYNC 13'h100
`define DSM_A_MIX 13'h101
`define DSM_A_FIR 13'h102
`define DSM_A_HB 13'h103
`define DSM_A_OVR 13'h104
`define DSM_A_COARSE 13'h105
`define DSM_A_FHI_L 13'h106
`define DSM_A_FHI_H 13'h107
`define DSM_A_FLO_L 13'h108
`define DSM_A_FLO_H 13'h109
`define DSM_A_DWELL_L 13'h10a
`define DSM_A_DWELL_H 13'h10b
`define DSM_A_DC 13'h10c
`define DSM_A_DCA_L 13'h10d
`define DSM_A_DCA_H 13'h10e
`define DSM_A_DCB_L 13'h10f
`define DSM_A_DCB_H 13'h110
`define DSM_A_MSER 13'h111
`define DSM_A_MCTL 13'h112
`define DSM_A_PER_L 13'h113
`define DSM_A_PER_M 13'h114
`define DSM_A_PER_H 13'h115
`define DSM_A_NCO 13'h11d
`define DSM_A_PH_L 13'h122
`define DSM_A_PH_H 13'h123
// ----------------------------------------
// Sync control field positions
// ----------------------------------------
`define DSM_B_MASTER 0
`define DSM_B_DIV_EN 1
`define DSM_B_DIV_ONE 2
`define DSM_B_NCO_EN 3
`define DSM_B_NCO_ONE 4
`define DSM_B_HB_EN 5
`define DSM_B_HB_ONE 6
`define DSM_B_MON_EN 7
`define DSM_B_FS8_EN 0
`define DSM_B_FS8_ONE 1
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define DSM_R_ZERO 8'h00
`define DSM_R_MSER 8'h04
`define DSM_R_PER_L 8'h80
`define DSM_PER_MIN 24'h000080
`define DSM_K_MAX 4'hd
`define DSM_LEN_WIDE 5'h13
`define DSM_LEN_NARROW 5'h0c
`endif

// file: dsm_buf2.v
// Two-entry valid/ready buffer for monitor result words.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dsm_buf2 #(
	parameter W = 22
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Filling side
	input wire [W-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	// Draining side
	output wire [W-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);
	reg [W-1:0] d0_q;
	reg [W-1:0] d1_q;
	reg [1:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o = d0_q;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_ready_i & out_valid_o;

	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			d0_q <= {W{1'b0}};
			d1_q <= {W{1'b0}};
			cnt_q <= 2'h0;
		end
		else
		begin
			if (push & ~pop)
			begin
				if (cnt_q == 2'h0)
					d0_q <= in_data_i;
				else
					d1_q <= in_data_i;
				cnt_q <= cnt_q + 2'h1;
			end
			else if (pop & ~push)
			begin
				d0_q <= d1_q;
				cnt_q <= cnt_q - 2'h1;
			end
			else if (pop & push)
			begin
				if (cnt_q == 2'h1)
					d0_q <= in_data_i;
				else
				begin
					d0_q <= d1_q;
					d1_q <= in_data_i;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: dsm_ctrl.v
// Control/status registers, sync gating, detect and monitor serial out.
// Assumes CLK_I is the divided sample clock; SPI SCLK at most CLK_I/8.
`timescale 1ns/1ps
`default_nettype none
`include "dsm_consts.vh"
module dsm_ctrl (
	// Clock and reset
	input wire CLK_I,
	input wire RESET_I,
	// Serial control port
	input wire SPI_SCLK_I,
	input wire SPI_CS_N_I,
	input wire SPI_SDIO_I,
	output reg SPI_SDIO_O,
	output reg SPI_SDIO_OE_O,
	// Sync pin and gated pulses
	input wire SYNC_I,
	output reg DIV_SYNC_O,
	output reg HB_SYNC_O,
	output reg NCO_LOAD_O,
	output reg FS8_SYNC_O,
	output reg MON_SYNC_O,
	// Datapath configuration
	output wire [15:0] NCO_PHASE_O,
	output wire NCO_EN_O,
	output wire [1:0] FS8_START_O,
	output wire FIR_EN_O,
	output wire FIR_GAIN_TWO_O,
	output wire COMPLEX_O,
	output wire FS8_BYPASS_O,
	output wire HB_ALT_PHASE_O,
	output wire HB_REVERSE_O,
	output wire HB_HIGHPASS_O,
	// Overrange detect
	input wire [12:0] ADC_MAG_I,
	input wire LVDS_IL_I,
	input wire CHAN_A_ON_I,
	input wire CHAN_B_ON_I,
	output wire [2:0] OVR_MODE_O,
	output reg OVR_PINS_OE_O,
	output wire [2:0] COARSE_LEVEL_O,
	output reg FINE_HIGH_O,
	output reg FINE_LOW_O,
	output reg RAISE_GAIN_O,
	// Offset removal
	input wire [13:0] DC_A_I,
	input wire [13:0] DC_B_I,
	output reg [3:0] DC_BW_O,
	output wire DC_FREEZE_O,
	output wire DC_PATH_O,
	output wire DC_MON_O,
	// Power monitor
	input wire [19:0] MON_RES_I,
	input wire [1:0] MON_KIND_I,
	input wire MON_VALID_I,
	output wire MON_READY_O,
	output wire [1:0] MON_MODE_O,
	output wire MON_MS_O,
	output wire MON_COMPLEX_O,
	output wire MON_EN_O,
	output reg MON_PERIOD_O,
	output reg MON_SCLK_O,
	output reg MON_SDATA_O,
	output reg MON_FRAME_O
);
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg [7:0] sync_q, mix_q, fir_q, hb_q, ovr_q, coarse_q, dc_q;
	reg [12:0] fhi_q, flo_q;
	reg [15:0] dwell_q, phase_q;
	reg [7:0] mser_q, mctl_q, nco_q;
	reg [23:0] per_q;
	reg [13:0] dca_q, dcb_q;
	reg wr_stb_q;
	reg [12:0] addr_q;
	reg [7:0] wr_data_q;
	reg [7:0] rd_data;

	assign NCO_PHASE_O = phase_q;
	assign NCO_EN_O = nco_q[0];
	assign FS8_START_O = mix_q[5:4];
	assign FIR_EN_O = fir_q[0];
	assign FIR_GAIN_TWO_O = ~fir_q[3];
	assign COMPLEX_O = fir_q[1];
	assign FS8_BYPASS_O = fir_q[2];
	assign HB_ALT_PHASE_O = hb_q[3];
	assign HB_REVERSE_O = hb_q[2];
	assign HB_HIGHPASS_O = hb_q[1];
	assign OVR_MODE_O = ovr_q[3:1];
	assign COARSE_LEVEL_O = coarse_q[2:0];
	assign DC_FREEZE_O = dc_q[6];
	assign DC_PATH_O = dc_q[1];
	assign DC_MON_O = dc_q[0];
	assign MON_MODE_O = mctl_q[2:1];
	assign MON_MS_O = mctl_q[3];
	assign MON_COMPLEX_O = mctl_q[7];
	assign MON_EN_O = mctl_q[0];

	// ----------------------------------------
	// Sync pin capture and gating
	// ----------------------------------------
	reg sy1_q, sy2_q, sy3_q, nco_en_d1_q;
	wire sync_go, div_hit, hb_hit, nco_hit, fs8_hit;

	assign sync_go = sy2_q & ~sy3_q & sync_q[`DSM_B_MASTER];
	assign div_hit = sync_go & sync_q[`DSM_B_DIV_EN];
	assign hb_hit = sync_go & sync_q[`DSM_B_HB_EN];
	assign nco_hit = sync_go & sync_q[`DSM_B_NCO_EN];
	assign fs8_hit = sync_go & mix_q[`DSM_B_FS8_EN];

	always @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			sy1_q <= 1'b0;
			sy2_q <= 1'b0;
			sy3_q <= 1'b0;
			nco_en_d1_q <= 1'b0;
			DIV_SYNC_O <= 1'b0;
			HB_SYNC_O <= 1'b0;
			NCO_LOAD_O <= 1'b0;
			FS8_SYNC_O <= 1'b0;
			MON_SYNC_O <= 1'b0;
		end
		else
		begin
			sy1_q <= SYNC_I;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			nco_en_d1_q <= nco_q[0];
			DIV_SYNC_O <= div_hit;
			HB_SYNC_O <= hb_hit;
			// load on sync or NCO start
			NCO_LOAD_O <= nco_hit | (nco_q[0] & ~nco_en_d1_q);
			FS8_SYNC_O <= fs8_hit;
			MON_SYNC_O <= sync_go & sync_q[`DSM_B_MON_EN];
		end
	end

	// ----------------------------------------
	// Register writes and self-clearing enables
	// ----------------------------------------
	always @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			sync_q <= `DSM_R_ZERO;
			mix_q <= `DSM_R_ZERO;
			fir_q <= `DSM_R_ZERO;
			hb_q <= `DSM_R_ZERO;
			ovr_q <= `DSM_R_ZERO;
			coarse_q <= `DSM_R_ZERO;
			fhi_q <= 13'h0000;
			flo_q <= 13'h0000;
			dwell_q <= 16'h0000;
			dc_q <= `DSM_R_ZERO;
			mser_q <= `DSM_R_MSER;
			mctl_q <= `DSM_R_ZERO;
			per_q <= {16'h0000, `DSM_R_PER_L};
			nco_q <= `DSM_R_ZERO;
			phase_q <= 16'h0000;
		end
		else
		begin
			// clear in the cycle the one-shot acts
			if (div_hit & sync_q[`DSM_B_DIV_ONE])
				sync_q[`DSM_B_DIV_EN] <= 1'b0;
			if (nco_hit & sync_q[`DSM_B_NCO_ONE])
				sync_q[`DSM_B_NCO_EN] <= 1'b0;
			if (hb_hit & sync_q[`DSM_B_HB_ONE])
				sync_q[`DSM_B_HB_EN] <= 1'b0;
			// fs/8 one-shot clears its own enable
			if (fs8_hit & mix_q[`DSM_B_FS8_ONE])
				mix_q[`DSM_B_FS8_EN] <= 1'b0;
			// Later assignment: a software write wins over a clear
			if (wr_stb_q)
			begin
				case (addr_q)
					`DSM_A_SYNC: sync_q <= wr_data_q;
					`DSM_A_MIX: mix_q <= wr_data_q & 8'h33;
					`DSM_A_FIR: fir_q <= wr_data_q & 8'h0f;
					`DSM_A_HB: hb_q <= wr_data_q & 8'h0e;
					`DSM_A_OVR: ovr_q <= wr_data_q & 8'h0f;
					`DSM_A_COARSE: coarse_q <= wr_data_q & 8'h07;
					`DSM_A_FHI_L: fhi_q[7:0] <= wr_data_q;
					`DSM_A_FHI_H: fhi_q[12:8] <= wr_data_q[4:0];
					`DSM_A_FLO_L: flo_q[7:0] <= wr_data_q;
					`DSM_A_FLO_H: flo_q[12:8] <= wr_data_q[4:0];
					`DSM_A_DWELL_L: dwell_q[7:0] <= wr_data_q;
					`DSM_A_DWELL_H: dwell_q[15:8] <= wr_data_q;
					`DSM_A_DC: dc_q <= wr_data_q & 8'h7f;
					`DSM_A_MSER: mser_q <= wr_data_q & 8'h7f;
					`DSM_A_MCTL: mctl_q <= wr_data_q & 8'h8f;
					`DSM_A_PER_L: per_q[7:0] <= wr_data_q;
					`DSM_A_PER_M: per_q[15:8] <= wr_data_q;
					`DSM_A_PER_H: per_q[23:16] <= wr_data_q;
					`DSM_A_NCO: nco_q <= wr_data_q & 8'h07;
					`DSM_A_PH_L: phase_q[7:0] <= wr_data_q;
					`DSM_A_PH_H: phase_q[15:8] <= wr_data_q;
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @*
	begin
		case (addr_q)
			`DSM_A_SYNC: rd_data = sync_q;
			`DSM_A_MIX: rd_data = mix_q;
			`DSM_A_FIR: rd_data = fir_q;
			`DSM_A_HB: rd_data = hb_q | 8'h01;
			`DSM_A_OVR: rd_data = ovr_q;
			`DSM_A_COARSE: rd_data = coarse_q;
			`DSM_A_FHI_L: rd_data = fhi_q[7:0];
			`DSM_A_FHI_H: rd_data = {3'h0, fhi_q[12:8]};
			`DSM_A_FLO_L: rd_data = flo_q[7:0];
			`DSM_A_FLO_H: rd_data = {3'h0, flo_q[12:8]};
			`DSM_A_DWELL_L: rd_data = dwell_q[7:0];
			`DSM_A_DWELL_H: rd_data = dwell_q[15:8];
			`DSM_A_DC: rd_data = dc_q;
			// offset estimates, low then high byte
			`DSM_A_DCA_L: rd_data = dca_q[7:0];
			`DSM_A_DCA_H: rd_data = {2'h0, dca_q[13:8]};
			`DSM_A_DCB_L: rd_data = dcb_q[7:0];
			`DSM_A_DCB_H: rd_data = {2'h0, dcb_q[13:8]};
			`DSM_A_MSER: rd_data = mser_q;
			`DSM_A_MCTL: rd_data = mctl_q;
			`DSM_A_PER_L: rd_data = per_q[7:0];
			`DSM_A_PER_M: rd_data = per_q[15:8];
			`DSM_A_PER_H: rd_data = per_q[23:16];
			`DSM_A_NCO: rd_data = nco_q;
			`DSM_A_PH_L: rd_data = phase_q[7:0];
			`DSM_A_PH_H: rd_data = phase_q[15:8];
			default: rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Serial control port slave
	// ----------------------------------------
	localparam SP_IDLE = 4'h1;
	localparam SP_INS = 4'h2;
	localparam SP_DAT = 4'h4;
	localparam SP_DONE = 4'h8;
	reg [3:0] sp_q;
	reg sk1_q, sk2_q, sk3_q, cs1_q, cs2_q, sd1_q, sd2_q;
	reg [15:0] sh_q;
	reg [4:0] bit_q;
	reg rnw_q, ld_q;
	reg [7:0] rsh_q;
	wire sk_rise, sk_fall;

	assign sk_rise = sk2_q & ~sk3_q;
	assign sk_fall = ~sk2_q & sk3_q;

	always @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			sk1_q <= 1'b0;
			sk2_q <= 1'b0;
			sk3_q <= 1'b0;
			cs1_q <= 1'b1;
			cs2_q <= 1'b1;
			sd1_q <= 1'b0;
			sd2_q <= 1'b0;
			sp_q <= SP_IDLE;
			sh_q <= 16'h0000;
			bit_q <= 5'h00;
			rnw_q <= 1'b0;
			ld_q <= 1'b0;
			rsh_q <= 8'h00;
			addr_q <= 13'h0000;
			wr_stb_q <= 1'b0;
			wr_data_q <= 8'h00;
			SPI_SDIO_O <= 1'b0;
			SPI_SDIO_OE_O <= 1'b0;
		end
		else
		begin
			sk1_q <= SPI_SCLK_I;
			sk2_q <= sk1_q;
			sk3_q <= sk2_q;
			cs1_q <= SPI_CS_N_I;
			cs2_q <= cs1_q;
			sd1_q <= SPI_SDIO_I;
			sd2_q <= sd1_q;
			wr_stb_q <= 1'b0;
			ld_q <= 1'b0;
			if (ld_q)
			begin
				rsh_q <= rd_data;
				SPI_SDIO_OE_O <= 1'b1;
			end
			if (cs2_q)
			begin
				sp_q <= SP_IDLE;
				SPI_SDIO_OE_O <= 1'b0;
			end
			else
			begin
				case (sp_q)
					SP_IDLE:
					begin
						bit_q <= 5'h00;
						sp_q <= SP_INS;
					end
					SP_INS:
						if (sk_rise)
						begin
							sh_q <= {sh_q[14:0], sd2_q};
							bit_q <= bit_q + 5'h01;
							if (bit_q == 5'h0f)
							begin
								rnw_q <= sh_q[14];
								addr_q <= {sh_q[11:0], sd2_q};
								ld_q <= sh_q[14];
								sp_q <= SP_DAT;
							end
						end
					SP_DAT:
					begin
						if (sk_fall & rnw_q)
						begin
							SPI_SDIO_O <= rsh_q[7];
							rsh_q <= {rsh_q[6:0], 1'b0};
						end
						if (sk_rise)
						begin
							sh_q <= {sh_q[14:0], sd2_q};
							bit_q <= bit_q + 5'h01;
							if (bit_q == 5'h17)
							begin
								wr_stb_q <= ~rnw_q;
								wr_data_q <= {sh_q[6:0], sd2_q};
								sp_q <= SP_DONE;
							end
						end
					end
					SP_DONE: ;
					default: sp_q <= SP_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Fast detect, offset capture, interval
	// ----------------------------------------
	reg [15:0] low_cnt_q;
	reg [23:0] per_cnt_q;
	wire [23:0] per_eff;
	wire below;

	assign below = ADC_MAG_I < flo_q;
	// short intervals stretched to the minimum
	assign per_eff = (per_q < `DSM_PER_MIN) ? `DSM_PER_MIN : per_q;

	always @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			low_cnt_q <= 16'h0000;
			FINE_HIGH_O <= 1'b0;
			FINE_LOW_O <= 1'b0;
			RAISE_GAIN_O <= 1'b0;
			OVR_PINS_OE_O <= 1'b0;
			DC_BW_O <= 4'h0;
			dca_q <= 14'h0000;
			dcb_q <= 14'h0000;
			per_cnt_q <= 24'h000000;
			MON_PERIOD_O <= 1'b0;
		end
		else
		begin
			FINE_HIGH_O <= ADC_MAG_I > fhi_q;
			if (!below)
			begin
				low_cnt_q <= 16'h0000;
				FINE_LOW_O <= 1'b0;
				RAISE_GAIN_O <= 1'b0;
			end
			else if (low_cnt_q >= dwell_q)
			begin
				FINE_LOW_O <= 1'b1;
				RAISE_GAIN_O <= 1'b1;
			end
			else
				low_cnt_q <= low_cnt_q + 16'h0001;
			// interleaved pins float only with both channels off
			OVR_PINS_OE_O <= ovr_q[0] &
				(~LVDS_IL_I | CHAN_A_ON_I | CHAN_B_ON_I);
			DC_BW_O <= (dc_q[5:2] > `DSM_K_MAX) ? `DSM_K_MAX : dc_q[5:2];
			if (!dc_q[6])
			begin
				dca_q <= DC_A_I;
				dcb_q <= DC_B_I;
			end
			// interval counter, restarted by monitor sync
			MON_PERIOD_O <= 1'b0;
			if (!mctl_q[0] || MON_SYNC_O)
				per_cnt_q <= 24'h000000;
			else if (per_cnt_q >= per_eff - 24'h000001)
			begin
				per_cnt_q <= 24'h000000;
				MON_PERIOD_O <= 1'b1;
			end
			else
				per_cnt_q <= per_cnt_q + 24'h000001;
		end
	end

	// ----------------------------------------
	// Monitor serial output
	// ----------------------------------------
	localparam MS_IDLE = 2'h1;
	localparam MS_SHIFT = 2'h2;
	reg [1:0] ms_q;
	reg [1:0] div_q;
	reg [19:0] msh_q;
	reg [4:0] left_q;
	wire [21:0] b_data;
	wire b_valid, tick, fall, run, pop, kind_on, wide;
	wire [1:0] half;

	// Stall here backs up into the result source
	dsm_buf2 #(.W(22)) u_buf (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.in_data_i({MON_KIND_I, MON_RES_I}),
		.in_valid_i(MON_VALID_I),
		.in_ready_o(MON_READY_O),
		.out_data_o(b_data),
		.out_valid_o(b_valid),
		.out_ready_i(pop)
	);

	// half periods 1, 2, 4 cycles; code 00 acts as 01
	assign half = (mser_q[3:2] == 2'h3) ? 2'h3 :
		(mser_q[3:2] == 2'h2) ? 2'h1 : 2'h0;
	assign tick = (div_q == half);
	assign fall = tick & MON_SCLK_O;
	// sleep idles clock low when nothing pending
	assign run = mser_q[0] & (~mser_q[1] | b_valid | ms_q[1]);
	assign pop = ms_q[0] & fall & mser_q[0] & b_valid;
	assign wide = (b_data[21:20] == 2'h0);
	assign kind_on = wide ? mser_q[6] :
		(b_data[21:20] == 2'h1) ? mser_q[5] : mser_q[4];

	always @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			ms_q <= MS_IDLE;
			div_q <= 2'h0;
			msh_q <= 20'h00000;
			left_q <= 5'h00;
			MON_SCLK_O <= 1'b0;
			MON_SDATA_O <= 1'b0;
			MON_FRAME_O <= 1'b0;
		end
		else
		begin
			div_q <= tick ? 2'h0 : div_q + 2'h1;
			if (tick & (run | MON_SCLK_O))
				MON_SCLK_O <= ~MON_SCLK_O;
			case (ms_q)
				MS_IDLE:
					if (pop & kind_on)
					begin
						msh_q <= wide ? b_data[19:0] :
							{b_data[12:0], 7'h00};
						MON_SDATA_O <= wide ? b_data[19] : b_data[12];
						left_q <= wide ? `DSM_LEN_WIDE : `DSM_LEN_NARROW;
						MON_FRAME_O <= 1'b1;
						ms_q <= MS_SHIFT;
					end
				MS_SHIFT:
					if (fall)
					begin
						if (left_q == 5'h00)
						begin
							MON_FRAME_O <= 1'b0;
							MON_SDATA_O <= 1'b0;
							ms_q <= MS_IDLE;
						end
						else
						begin
							msh_q <= {msh_q[18:0], 1'b0};
							MON_SDATA_O <= msh_q[18];
							left_q <= left_q - 5'h01;
						end
					end
				default: ms_q <= MS_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: dsm_host.sv
// Control-port host model: one register per select frame.
// Assumes clk_i is the block clock; SCLK runs at clk_i/12.
`timescale 1ns/1ps
`default_nettype none
module dsm_host (
	// Clock
	input wire logic clk_i,
	// Control port
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdio_o,
	input wire logic sdio_i
);
	initial
	begin
		sclk_o = 1'h0;
		cs_n_o = 1'h1;
		sdio_o = 1'h0;
	end
	// Released data line toggles, so stale bits never pass as data
	task automatic xfer(input logic rd, input logic [12:0] a,
		input logic [7:0] wd, output logic [7:0] rdat);
		logic [23:0] sh;
		sh = {rd, 2'h0, a, wd};
		rdat = 8'h00;
		cs_n_o <= 1'h0;
		for (int i = 23; i >= 0; i--)
		begin
			@(posedge clk_i);
			sclk_o <= 1'h0;
			sdio_o <= (rd && i < 8) ? ~sdio_o : sh[i];
			repeat (6) @(posedge clk_i);
			sclk_o <= 1'h1;
			if (i < 8)
				rdat[i] = sdio_i;
			repeat (5) @(posedge clk_i);
		end
		@(posedge clk_i);
		sclk_o <= 1'h0;
		repeat (6) @(posedge clk_i);
		cs_n_o <= 1'h1;
		repeat (8) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// file: dsm_ctrl_chk.sv
// Checker for sync pulses, detect flags, bandwidth clamp and interval.
// Assumes it is bound into dsm_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dsm_ctrl_chk (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic SYNC_I,
	input wire logic DIV_SYNC_O,
	input wire logic HB_SYNC_O,
	input wire logic NCO_LOAD_O,
	input wire logic FS8_SYNC_O,
	input wire logic MON_SYNC_O,
	input wire logic [12:0] ADC_MAG_I,
	input wire logic FINE_HIGH_O,
	input wire logic FINE_LOW_O,
	input wire logic RAISE_GAIN_O,
	input wire logic [3:0] DC_BW_O,
	input wire logic MON_PERIOD_O
);
	logic [7:0] gap_q;
	wire any_sync = DIV_SYNC_O | HB_SYNC_O | FS8_SYNC_O | MON_SYNC_O;
	// Cycles since last interval pulse, saturating
	always @(posedge CLK_I or posedge RESET_I)
		if (RESET_I)
			gap_q <= 8'h00;
		else if (MON_PERIOD_O)
			gap_q <= 8'h00;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	a_sync_after_pin: assert property (any_sync |-> $past(SYNC_I, 2))
		else $error("gated sync without pin");
	a_sync_single: assert property (any_sync |=> !any_sync)
		else $error("gated sync longer than one cycle");
	a_nco_single: assert property (NCO_LOAD_O |=> !NCO_LOAD_O)
		else $error("phase load longer than one cycle");
	a_high_zero: assert property ($past(ADC_MAG_I) == 13'h0000 |-> !FINE_HIGH_O)
		else $error("high flag on zero magnitude");
	a_low_full: assert property ($past(ADC_MAG_I) == 13'h1fff |-> !FINE_LOW_O)
		else $error("low flag on full magnitude");
	a_gain_pair: assert property (FINE_LOW_O == RAISE_GAIN_O)
		else $error("gain indication differs from low flag");
	a_bw_clamp: assert property (DC_BW_O <= 4'hd)
		else $error("bandwidth above thirteen");
	a_period_min: assert property (MON_PERIOD_O |-> gap_q >= 8'h7f)
		else $error("interval shorter than 128");
endmodule
bind dsm_ctrl dsm_ctrl_chk chk_u (
	.CLK_I(CLK_I), .RESET_I(RESET_I), .SYNC_I(SYNC_I),
	.DIV_SYNC_O(DIV_SYNC_O), .HB_SYNC_O(HB_SYNC_O), .NCO_LOAD_O(NCO_LOAD_O),
	.FS8_SYNC_O(FS8_SYNC_O), .MON_SYNC_O(MON_SYNC_O), .ADC_MAG_I(ADC_MAG_I),
	.FINE_HIGH_O(FINE_HIGH_O), .FINE_LOW_O(FINE_LOW_O),
	.RAISE_GAIN_O(RAISE_GAIN_O), .DC_BW_O(DC_BW_O),
	.MON_PERIOD_O(MON_PERIOD_O));
`default_nettype wire

// file: tb.sv
// Self-checking bench for the register, sync, detect and monitor block.
// Assumes the host model owns the control port; SDIO resolved here.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst, sync, lvds, on_a, on_b, mvalid, sdio_h, sclk, cs_n;
	logic sdo, sdo_oe, dsy, hsy, nsy, fsy, msy, fir_en, gain2, cplx, byp;
	logic ovr_oe, fhi, flo, mrdy, msclk, msd, mfr, msclk_q, acc;
	logic [12:0] mag;
	logic [13:0] dca, dcb;
	logic [19:0] mres, rx, cnt, base;
	logic [1:0] mkind, fs8st;
	logic [3:0] bw;
	logic [15:0] ph;
	logic [7:0] rd;
	int fails, check_count, nbits;
	wire sdio_w = sdo_oe ? sdo : sdio_h;
	// Address, write value, expected read back
	logic [28:0] rows [10] = '{
		{13'h10d, 8'h55, 8'hbc}, {13'h10e, 8'h55, 8'h2a},
		{13'h102, 8'hff, 8'h0f}, {13'h103, 8'h00, 8'h01},
		{13'h104, 8'hff, 8'h0f}, {13'h105, 8'hff, 8'h07},
		{13'h107, 8'hff, 8'h1f}, {13'h10c, 8'hff, 8'h7f},
		{13'h112, 8'hff, 8'h8f}, {13'h130, 8'hff, 8'h00}};
	dsm_host host_u (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
		.sdio_o(sdio_h), .sdio_i(sdio_w));
	dsm_ctrl dut_u (.CLK_I(clk), .RESET_I(rst), .SPI_SCLK_I(sclk),
		.SPI_CS_N_I(cs_n), .SPI_SDIO_I(sdio_w), .SPI_SDIO_O(sdo),
		.SPI_SDIO_OE_O(sdo_oe), .SYNC_I(sync), .DIV_SYNC_O(dsy),
		.HB_SYNC_O(hsy), .NCO_LOAD_O(nsy), .FS8_SYNC_O(fsy), .MON_SYNC_O(msy),
		.NCO_PHASE_O(ph), .NCO_EN_O(), .FS8_START_O(fs8st), .FIR_EN_O(fir_en),
		.FIR_GAIN_TWO_O(gain2), .COMPLEX_O(cplx), .FS8_BYPASS_O(byp),
		.HB_ALT_PHASE_O(), .HB_REVERSE_O(), .HB_HIGHPASS_O(),
		.ADC_MAG_I(mag), .LVDS_IL_I(lvds), .CHAN_A_ON_I(on_a),
		.CHAN_B_ON_I(on_b), .OVR_MODE_O(), .OVR_PINS_OE_O(ovr_oe),
		.COARSE_LEVEL_O(), .FINE_HIGH_O(fhi), .FINE_LOW_O(flo),
		.RAISE_GAIN_O(), .DC_A_I(dca), .DC_B_I(dcb), .DC_BW_O(bw),
		.DC_FREEZE_O(), .DC_PATH_O(), .DC_MON_O(), .MON_RES_I(mres),
		.MON_KIND_I(mkind), .MON_VALID_I(mvalid), .MON_READY_O(mrdy),
		.MON_MODE_O(), .MON_MS_O(), .MON_COMPLEX_O(), .MON_EN_O(),
		.MON_PERIOD_O(), .MON_SCLK_O(msclk), .MON_SDATA_O(msd),
		.MON_FRAME_O(mfr));
	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	// Pulse counts, one nibble each: div, hb, nco, fs8, monitor
	always @(posedge clk)
	begin
		// Cleared in reset so unknown pulses before reset never stick
		if (rst)
			cnt <= 20'h00000;
		else
			cnt <= cnt + {3'h0, dsy, 3'h0, hsy, 3'h0, nsy,
				3'h0, fsy, 3'h0, msy};
		msclk_q <= msclk;
		if (msclk && !msclk_q && mfr)
		begin
			rx <= {rx[18:0], msd};
			nbits <= nbits + 1;
		end
	end
	task automatic chk(input string n, input logic [19:0] s, e);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host_u.xfer(1'h0, a, d, rd);
	endtask
	task automatic rc(input logic [12:0] a, input logic [7:0] e);
		host_u.xfer(1'h1, a, 8'h00, rd);
		chk("read", {12'h000, rd}, {12'h000, e});
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			sync <= 1'h1;
			repeat (8) @(posedge clk);
			sync <= 1'h0;
			repeat (8) @(posedge clk);
		end
	endtask
	// Single attempt; acc tells whether the buffer took the word
	task automatic push(input logic [21:0] w);
		{mkind, mres} <= w;
		mvalid <= 1'h1;
		@(posedge clk);
		acc = mrdy;
		mvalid <= 1'h0;
		@(posedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		// Hang guard, well above the expected run length
		repeat (60000) @(posedge clk);
		fails++;
		print_verdict();
	end
	initial
	begin
		{rst, on_a, on_b, mag} = {3'h7, 13'h1fff};
		{sync, lvds, mvalid, mkind, mres, cnt, rx, nbits} = 0;
		{dca, dcb} = {14'h2abc, 14'h0000};
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			wr(rows[i][28:16], rows[i][15:8]);
			rc(rows[i][28:16], rows[i][7:0]);
		end
		chk("fir", {16'h0, fir_en, gain2, cplx, byp}, 20'hb);
		wr(13'h102, 8'h06);
		chk("fir", {16'h0, fir_en, gain2, cplx, byp}, 20'h7);
		chk("bw", {16'h0, bw}, 20'hd);
		dca <= 14'h0123;
		rc(13'h10d, 8'hbc);
		wr(13'h10c, 8'h08);
		rc(13'h10d, 8'h23);
		chk("bw", {16'h0, bw}, 20'h2);
		{lvds, on_a, on_b} <= 3'h4;
		repeat (3) @(posedge clk);
		chk("pins", {19'h0, ovr_oe}, 20'h0);
		on_a <= 1'h1;
		repeat (3) @(posedge clk);
		chk("pins", {19'h0, ovr_oe}, 20'h1);
		wr(13'h100, 8'hfe);
		wr(13'h101, 8'h33);
		chk("start", {18'h0, fs8st}, 20'h3);
		base = cnt;
		pulse(1);
		chk("gated off", cnt - base, 20'h0);
		wr(13'h100, 8'hff);
		base = cnt;
		pulse(2);
		chk("one shot", cnt - base, 20'h11112);
		rc(13'h100, 8'hd5);
		rc(13'h101, 8'h32);
		wr(13'h100, 8'h2b);
		wr(13'h101, 8'h01);
		base = cnt;
		pulse(2);
		chk("continuous", cnt - base, 20'h22220);
		base = cnt;
		wr(13'h122, 8'h34);
		wr(13'h123, 8'h12);
		wr(13'h11d, 8'h01);
		chk("nco start", cnt - base, 20'h00100);
		chk("phase", {4'h0, ph}, 20'h01234);
		wr(13'h106, 8'h00);
		wr(13'h107, 8'h01);
		wr(13'h108, 8'h40);
		wr(13'h10a, 8'h05);
		mag <= 13'h0101;
		repeat (3) @(posedge clk);
		chk("high", {19'h0, fhi}, 20'h1);
		mag <= 13'h0100;
		repeat (3) @(posedge clk);
		chk("high", {19'h0, fhi}, 20'h0);
		mag <= 13'h0000;
		repeat (4) @(posedge clk);
		chk("low", {19'h0, flo}, 20'h0);
		repeat (5) @(posedge clk);
		chk("low", {19'h0, flo}, 20'h1);
		mag <= 13'h0040;
		repeat (3) @(posedge clk);
		chk("low", {19'h0, flo}, 20'h0);
		wr(13'h113, 8'h10);
		wr(13'h111, 8'h40);
		push({2'h0, 20'habcde});
		push({2'h0, 20'h12345});
		push({2'h0, 20'h55555});
		chk("full", {18'h0, acc, mrdy}, 20'h0);
		wr(13'h111, 8'h45);
		for (int k = 0; k < 400 && nbits < 40; k++)
			@(posedge clk);
		chk("bits", nbits[19:0], 20'h28);
		chk("word", rx, 20'h12345);
		push({2'h1, 20'h00fff});
		repeat (100) @(posedge clk);
		chk("dropped", nbits[19:0], 20'h28);
		wr(13'h111, 8'h4b);
		chk("sleep", {19'h0, msclk}, 20'h0);
		push({2'h0, 20'h0f0f0});
		repeat (60) @(posedge clk);
		chk("div4", {19'h0, nbits < 60}, 20'h1);
		for (int k = 0; k < 100 && nbits < 60; k++)
			@(posedge clk);
		chk("bits", nbits[19:0], 20'h3c);
		chk("word", rx, 20'h0f0f0);
		repeat (8) @(posedge clk);
		chk("sleep", {19'h0, msclk}, 20'h0);
		rst <= 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rc(13'h111, 8'h04);
		rc(13'h113, 8'h80);
		rc(13'h103, 8'h01);
		rc(13'h100, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
